//--- core/ptr_flag_pkg.sv
/*
  constants, state codes and the sign-extension helper shared by the pointer and
  flag register block and its reset vector fetcher.
  assumes a single core clock and a synchronous, active high reset.
*/
package ptr_flag_pkg;

  // stack pointer
  localparam logic [15:0] STACK_RESET_VALUE   = 16'h00FF;
  localparam logic [7:0]  STACK_LOW_RESET     = 8'hFF;
  localparam logic [15:0] STACK_STEP          = 16'h0001;

  // program counter
  localparam logic [15:0] COUNTER_RESET_VALUE = 16'h0000;
  localparam logic [15:0] COUNTER_STEP        = 16'h0001;
  localparam logic [15:0] VEC_HI_ADDR         = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR         = 16'hFFFF;

  // condition flags: V 1 1 H I N Z C
  localparam int          FLAG_MASK_BIT       = 3;
  localparam int          FLAG_ONE_HI_BIT     = 6;
  localparam int          FLAG_ONE_LO_BIT     = 5;
  localparam logic [7:0]  FLAGS_ONES          = 8'h60;
  localparam logic [7:0]  FLAGS_RESET_VALUE   = 8'h68;

  typedef enum logic [1:0] {
    VEC_FETCH_HI = 2'b00,
    VEC_FETCH_LO = 2'b01,
    VEC_DONE     = 2'b10
  } vec_state_t;

  function automatic logic [15:0] sign_extend(input logic [7:0] imm);
    sign_extend = {{8{imm[7]}}, imm};
  endfunction

endpackage

//--- core/reset_vector_fetch.sv
/*
  reset vector fetcher: after reset reads the two vector bytes and hands the
  assembled start address to the register block.
  assumes the memory answers each held request with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
module reset_vector_fetch
  import ptr_flag_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        valid_i,
  output logic             req_o,
  output logic [15:0]      addr_o,
  output logic             load_o,
  output logic [15:0]      vec_o
);

  vec_state_t state;
  logic [7:0] hi_byte;
  wire        take_hi = req_o && valid_i && (state == VEC_FETCH_HI);
  wire        take_lo = req_o && valid_i && (state == VEC_FETCH_LO);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= VEC_FETCH_HI;
      req_o   <= 1'b0;
      addr_o  <= VEC_HI_ADDR;
      load_o  <= 1'b0;
      vec_o   <= COUNTER_RESET_VALUE;
      hi_byte <= 8'h00;
    end else begin
      load_o <= 1'b0;
      case (state)
        VEC_FETCH_HI: begin
          req_o <= 1'b1;
          if (take_hi) begin
            hi_byte <= data_i;  // lower address is the upper byte [RL12]
            addr_o  <= VEC_LO_ADDR;
            state   <= VEC_FETCH_LO;
          end
        end
        VEC_FETCH_LO: begin
          if (take_lo) begin
            vec_o  <= {hi_byte, data_i};  // [RL12] [RL9]
            load_o <= 1'b1;
            req_o  <= 1'b0;
            state  <= VEC_DONE;
          end
        end
        VEC_DONE: begin
          req_o <= 1'b0;
        end
        default: begin
          state <= VEC_FETCH_HI;
          req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- core/cpu_pointer_and_flag_regs.sv
/*
  programmer-visible stack pointer, program counter and condition flags of an
  8-bit core, with reset vector fetch ahead of the first instruction.
  assumes the sequencer drives one-cycle strobes on the core clock and that the
  memory answers vector reads with a one-cycle valid strobe.
*/
//
// Contract
// (RL1) stack pointer is 16 bits and points at the next free stack byte
// (RL2) reset forces the stack pointer to 0x00FF
// (RL3) stack adjust adds a sign-extended 8-bit immediate to all 16 bits
// (RL4) stack low reset changes only the low byte, upper byte kept
// (RL5) call pushes return address; interrupt pushes return address and registers
// (RL6) program counter is 16 bits, address of the next fetched byte
// (RL7) every byte fetch advances the program counter by one
// (RL8) jumps, taken branches, interrupts and returns load a target instead
// (RL9) after reset the counter loads from the vector at 0xFFFE and 0xFFFF
// (RL10) flags are 8 bits: interrupt mask plus five result flags
// (RL11) flag bits 6 and 5 always read as one, never written
// (RL12) vector is big-endian: lower address gives the upper byte
`timescale 1ns/1ps
module cpu_pointer_and_flag_regs
  import ptr_flag_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        FETCH_I,
  input  wire logic        FLOW_LOAD_I,
  input  wire logic [15:0] FLOW_ADDR_I,
  input  wire logic        STACK_ADJ_I,
  input  wire logic [7:0]  STACK_IMM_I,
  input  wire logic        STACK_LOW_RST_I,
  input  wire logic        STACK_LOAD_I,
  input  wire logic [15:0] STACK_DATA_I,
  input  wire logic        STACK_PUSH_I,
  input  wire logic        STACK_PULL_I,
  input  wire logic        FLAGS_WE_I,
  input  wire logic [7:0]  FLAGS_DATA_I,
  input  wire logic        INT_ENTRY_I,
  input  wire logic [7:0]  VEC_DATA_I,
  input  wire logic        VEC_VALID_I,
  output logic [15:0]      STACK_POINTER_O,
  output logic [15:0]      PROGRAM_COUNTER_O,
  output logic [7:0]       FLAGS_O,
  output logic             READY_O,
  output logic             VEC_REQ_O,
  output logic [15:0]      VEC_ADDR_O
);

  logic [15:0] stack_pointer;
  logic [15:0] program_counter;
  logic [7:0]  condition_flags_register;
  logic        ready;
  logic        vec_load;
  logic [15:0] vec_value;

  reset_vector_fetch vec_fetch (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RESET_I),
    .data_i  (VEC_DATA_I),
    .valid_i (VEC_VALID_I),
    .req_o   (VEC_REQ_O),
    .addr_o  (VEC_ADDR_O),
    .load_o  (vec_load),
    .vec_o   (vec_value)
  );

  // stack operations, one per cycle, adjust first
  wire        do_adj   = ready && STACK_ADJ_I;
  wire        do_low   = ready && !STACK_ADJ_I && STACK_LOW_RST_I;
  wire        do_load  = ready && !STACK_ADJ_I && !STACK_LOW_RST_I && STACK_LOAD_I;
  wire        stack_busy = STACK_ADJ_I || STACK_LOW_RST_I || STACK_LOAD_I;
  wire        do_push    = ready && !stack_busy && STACK_PUSH_I;
  wire        do_pull    = ready && !stack_busy && !STACK_PUSH_I && STACK_PULL_I;
  wire [15:0] stack_sum  = stack_pointer + sign_extend(STACK_IMM_I);  // [RL3]
  wire [15:0] stack_low  = {stack_pointer[15:8], STACK_LOW_RESET};    // [RL4]
  wire [15:0] next_stack = do_adj  ? stack_sum :
                           do_low  ? stack_low :
                           do_load ? STACK_DATA_I :
                           do_push ? stack_pointer - STACK_STEP :     // [RL5] [RL1]
                           do_pull ? stack_pointer + STACK_STEP :
                                     stack_pointer;

  // program counter: change of flow beats the sequential step
  wire        do_flow  = ready && FLOW_LOAD_I;
  wire        do_fetch = ready && !FLOW_LOAD_I && FETCH_I;
  wire [15:0] next_count = vec_load ? vec_value :                    // [RL9]
                           do_flow  ? FLOW_ADDR_I :                  // [RL8]
                           do_fetch ? program_counter + COUNTER_STEP : // [RL7]
                                      program_counter;

  // condition flags: interrupt entry sets the mask even over a write
  wire [7:0]  flags_wr   = FLAGS_WE_I && ready ? FLAGS_DATA_I : condition_flags_register;
  wire [7:0]  mask_bit   = (ready && INT_ENTRY_I) ? (8'h01 << FLAG_MASK_BIT) : 8'h00;
  wire [7:0]  next_flags = flags_wr | mask_bit | FLAGS_ONES;        // [RL10] [RL11]

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      stack_pointer <= STACK_RESET_VALUE;                            // [RL2]
    end else begin
      stack_pointer <= next_stack;                                   // [RL1]
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      program_counter <= COUNTER_RESET_VALUE;
      ready           <= 1'b0;
    end else begin
      program_counter <= next_count;                                 // [RL6]
      if (vec_load) begin
        ready <= 1'b1;                                               // [RL9]
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      condition_flags_register <= FLAGS_RESET_VALUE;
    end else begin
      condition_flags_register <= next_flags;                        // [RL10]
    end
  end

  assign STACK_POINTER_O   = stack_pointer;
  assign PROGRAM_COUNTER_O = program_counter;
  assign FLAGS_O           = condition_flags_register;
  assign READY_O           = ready;

  // checks
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);

  logic [7:0] seen_hi;
  logic [7:0] seen_lo;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      seen_hi <= 8'h00;
      seen_lo <= 8'h00;
    end else if (VEC_REQ_O && VEC_VALID_I) begin
      if (VEC_ADDR_O == VEC_HI_ADDR) begin
        seen_hi <= VEC_DATA_I;
      end else begin
        seen_lo <= VEC_DATA_I;
      end
    end
  end

  stack_reset_a: assert property (                                    // [RL2]
    $fell(RESET_I) |-> stack_pointer == STACK_RESET_VALUE && !ready)
    else $error("stack pointer not at reset value after reset");

  flag_ones_a: assert property (                                      // [RL11]
    condition_flags_register[FLAG_ONE_HI_BIT] && condition_flags_register[FLAG_ONE_LO_BIT])
    else $error("fixed flag bits not one");

  flags_write_a: assert property (                                    // [RL10] [RL11]
    ready && FLAGS_WE_I && !INT_ENTRY_I
      |=> condition_flags_register == ($past(FLAGS_DATA_I) | FLAGS_ONES))
    else $error("flag write result wrong");

  stack_adjust_a: assert property (                                   // [RL3]
    do_adj |=> stack_pointer == $past(stack_pointer) + sign_extend($past(STACK_IMM_I)))
    else $error("stack adjust result wrong");

  stack_low_a: assert property (                                      // [RL4]
    do_low |=> stack_pointer[15:8] == $past(stack_pointer[15:8])
               && stack_pointer[7:0] == STACK_LOW_RESET)
    else $error("stack low reset touched wrong byte");

  stack_load_a: assert property (                                     // [RL1]
    do_load |=> stack_pointer == $past(STACK_DATA_I))
    else $error("stack load value not taken");

  stack_push_a: assert property (                                     // [RL5]
    do_push ##1 do_push |=> stack_pointer == $past(stack_pointer, 2) - 16'h0002)
    else $error("two pushes did not move stack pointer by two");

  stack_pull_a: assert property (                                     // [RL1]
    do_pull |=> stack_pointer == $past(stack_pointer) + STACK_STEP)
    else $error("pull did not move stack pointer up by one");

  count_step_a: assert property (                                     // [RL7]
    do_fetch |=> program_counter == $past(program_counter) + COUNTER_STEP)
    else $error("program counter did not step on fetch");

  count_flow_a: assert property (                                     // [RL8]
    do_flow |=> program_counter == $past(FLOW_ADDR_I))
    else $error("change of flow target not loaded");

  count_vec_a: assert property (                                      // [RL9]
    vec_load |=> program_counter == $past(vec_value))
    else $error("start address not loaded into program counter");

  vec_first_a: assert property (                                      // [RL9]
    $fell(RESET_I) |=> VEC_REQ_O && VEC_ADDR_O == VEC_HI_ADDR)
    else $error("vector fetch did not start at high vector byte");

  vec_hold_a: assert property (                                       // [RL9]
    VEC_REQ_O && !VEC_VALID_I |=> VEC_REQ_O && $stable(VEC_ADDR_O))
    else $error("vector request dropped before answer");

  vec_order_a: assert property (                                      // [RL12]
    $rose(ready) |-> program_counter == {seen_hi, seen_lo})
    else $error("start address not assembled big-endian");

  ready_stays_a: assert property (                                    // [RL9]
    ready |=> ready)
    else $error("ready fell without reset");

  early_hold_a: assert property (                                     // [RL9]
    !ready |-> !$changed(stack_pointer) && !$changed(condition_flags_register))
    else $error("registers moved before vector fetch done");

  mask_set_a: assert property (                                       // [RL10]
    ready && INT_ENTRY_I |=> condition_flags_register[FLAG_MASK_BIT])
    else $error("interrupt entry did not set mask");

  vec_done_c:  cover property ($rose(ready));
  adj_neg_c:   cover property (do_adj && STACK_IMM_I[7]);
  low_rst_c:   cover property (do_low);
  flow_c:      cover property (do_flow ##1 do_fetch);
  int_push_c:  cover property (INT_ENTRY_I && do_push ##1 do_push);

endmodule

//--- verification/cpu_pointer_and_flag_regs_tb.sv
/*
  self-checking bench for the pointer and flag register block.
  assumes the block carries its own assertions and runs on one core clock.
*/
`timescale 1ns/1ps
module cpu_pointer_and_flag_regs_tb
  import ptr_flag_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        fetch;
  logic        flow;
  logic        adj;
  logic        lowr;
  logic        load;
  logic        push;
  logic        pull;
  logic        fwe;
  logic        ient;
  logic        vvalid;
  logic        hung;
  logic [15:0] faddr;
  logic [15:0] sdata;
  logic [7:0]  imm;
  logic [7:0]  fdata;
  logic [7:0]  vdata;
  wire  [15:0] stack_ptr;
  wire  [15:0] prog_cnt;
  wire  [15:0] vaddr;
  wire  [7:0]  flags;
  wire         ready;
  wire         vreq;
  int          err_total;
  int          checks;

  cpu_pointer_and_flag_regs i_dut (
    .CORE_CLK_I(clk), .RESET_I(rst), .FETCH_I(fetch), .FLOW_LOAD_I(flow),
    .FLOW_ADDR_I(faddr), .STACK_ADJ_I(adj), .STACK_IMM_I(imm),
    .STACK_LOW_RST_I(lowr), .STACK_LOAD_I(load), .STACK_DATA_I(sdata),
    .STACK_PUSH_I(push), .STACK_PULL_I(pull), .FLAGS_WE_I(fwe),
    .FLAGS_DATA_I(fdata), .INT_ENTRY_I(ient), .VEC_DATA_I(vdata),
    .VEC_VALID_I(vvalid), .STACK_POINTER_O(stack_ptr), .PROGRAM_COUNTER_O(prog_cnt),
    .FLAGS_O(flags), .READY_O(ready), .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task step;
    @(posedge clk);
    #2;
  endtask

  task drop;
    {fetch, flow, adj, lowr, load, push, pull, fwe, ient, vvalid} = 10'h000;
  endtask

  // drops every strobe and lets one edge pass
  task idle;
    drop;
    step;
  endtask

  // a used-up wait bound counts as a mismatch
  task note_timeout(input int n);
    if (n == 10) begin
      hung = 1'b1;
      err_total++;
    end
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task print_verdict;
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task t_reset;
    chk("stack_ptr", 16'h00FF, stack_ptr);
    chk("prog_cnt", 16'h0000, prog_cnt);
    chk("flags", 16'h0068, {8'h00, flags});
    chk("ready", 16'h0000, {15'h0000, ready});
    chk("vec_req", 16'h0000, {15'h0000, vreq});
  endtask

  // releases reset and serves the vector with one wait state; strobes held
  // high meanwhile must be ignored, and a stray valid before the request refused
  task t_vector(input logic [15:0] vec, input logic stray);
    int i;
    {fetch, adj, fwe} = 3'b111;
    imm = 8'h01;
    fdata = 8'h00;
    vdata = 8'hAA;
    vvalid = stray;
    rst = 1'b0;
    step;
    vvalid = 1'b0;
    for (i = 0; i < 10 && vreq !== 1'b1; i++) step;
    note_timeout(i);
    chk("vec_addr", 16'hFFFE, vaddr);
    step;
    chk("vec_addr", 16'hFFFE, vaddr);
    chk("vec_req", 16'h0001, {15'h0000, vreq});
    vdata = vec[15:8];
    vvalid = 1'b1;
    step;
    chk("vec_addr", 16'hFFFF, vaddr);
    vdata = vec[7:0];
    step;
    idle;
    for (i = 0; i < 10 && ready !== 1'b1; i++) step;
    note_timeout(i);
    chk("prog_cnt", vec, prog_cnt);
    chk("vec_req", 16'h0000, {15'h0000, vreq});
    chk("stack_ptr", 16'h00FF, stack_ptr);
    chk("flags", 16'h0068, {8'h00, flags});
  endtask

  task t_pc;
    fetch = 1'b1;
    repeat (3) step;
    idle;
    chk("prog_cnt", 16'h1237, prog_cnt);
    flow = 1'b1;
    faddr = 16'hFFFF;
    fetch = 1'b1;
    step;
    chk("prog_cnt", 16'hFFFF, prog_cnt);
    flow = 1'b0;
    step;
    idle;
    chk("prog_cnt", 16'h0000, prog_cnt);
  endtask

  task t_stack;
    adj = 1'b1;
    imm = 8'hFE;
    step;
    chk("stack_ptr", 16'h00FD, stack_ptr);
    imm = 8'h7F;
    step;
    idle;
    chk("stack_ptr", 16'h017C, stack_ptr);
    lowr = 1'b1;
    step;
    idle;
    chk("stack_ptr", 16'h01FF, stack_ptr);
    load = 1'b1;
    sdata = 16'h8001;
    step;
    load = 1'b0;
    adj = 1'b1;
    imm = 8'h80;
    step;
    chk("stack_ptr", 16'h7F81, stack_ptr);
    adj = 1'b0;
    push = 1'b1;
    repeat (2) step;
    push = 1'b0;
    pull = 1'b1;
    step;
    idle;
    chk("stack_ptr", 16'h7F80, stack_ptr);
  endtask

  task t_flags;
    fwe = 1'b1;
    fdata = 8'h97;
    step;
    chk("flags", 16'h00F7, {8'h00, flags});
    fdata = 8'h00;
    step;
    chk("flags", 16'h0060, {8'h00, flags});
    ient = 1'b1;
    step;
    idle;
    chk("flags", 16'h0068, {8'h00, flags});
  endtask

  initial begin
    err_total = 0;
    checks = 0;
    hung = 1'b0;
    rst = 1'b1;
    drop;
    faddr = 16'h0000;
    sdata = 16'h0000;
    imm = 8'h00;
    fdata = 8'h00;
    vdata = 8'h00;
    repeat (3) step;
    t_reset;
    repeat (3) step;
    t_vector(16'h1234, 1'b0);
    if (!hung) begin
      t_pc;
      t_stack;
      t_flags;
      rst = 1'b1;
      repeat (2) step;
      t_reset;
      t_vector(16'h5678, 1'b1);
    end
    print_verdict;
  end
endmodule
